// ### hw/toes_pkg.sv
// shared constants and carrier types of the timed output entry scheduler
package toes_pkg;
	// fixed image lengths in bytes and in four-byte slots
	localparam logic [7:0] IN_LEN = 8'h04;
	localparam logic [7:0] OUT_LEN_SHORT = 8'h14;
	localparam logic [7:0] OUT_LEN_LONG = 8'h3c;
	localparam int SLOTS_SHORT = 5;
	localparam int SLOTS_LONG = 15;
	// byte positions inside one four-byte entry
	localparam logic [5:0] OFS_STATE = 6'h00;
	localparam logic [5:0] OFS_SEQ = 6'h01;
	localparam logic [5:0] OFS_TIME_LO = 6'h02;
	localparam logic [5:0] OFS_TIME_HI = 6'h03;
	// sequence numbering
	localparam logic [5:0] SEQ_START = 6'h01;
	localparam int SEQ_END_BIT = 6;
	// tag bits placed above the sequence numbers in the status image
	localparam logic [1:0] LAST_TAG = 2'h1;
	localparam logic [1:0] NEXT_TAG = 2'h3;
	// queue state codes; bit 7 is or-ed in while an end-marked entry is queued
	localparam logic [1:0] CODE_OK = 2'h0;
	localparam logic [1:0] CODE_MISMATCH = 2'h1;
	localparam logic [1:0] CODE_NONE = 2'h2;
	localparam logic [1:0] CODE_FULL = 2'h3;
	localparam int END_OR_BIT = 7;
	// microsecond ticker timing and default queue depth
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000;
	localparam int CYC_PER_US = TICK_NS / CLK_PERIOD_NS;
	localparam int FIFO_DEPTH_DEF = 31;

	typedef struct packed {
		logic endFlag;
		logic [5:0] seq;
		logic [3:0] state;
		logic [15:0] timeUs;
	} toes_entry_t;

	typedef struct packed {
		logic [7:0] lastAccepted;
		logic [7:0] nextExecuted;
		logic [7:0] queueState;
		logic [7:0] entryCount;
	} toes_status_t;
endpackage

// ### hw/toes_scheduler.sv
// timed output entry scheduler: output image intake, entry queue and timed output update
`timescale 1ns/10ps
module toes_scheduler
	import toes_pkg::*;
#(
	parameter bit LONG_VARIANT = 1'b0,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
	parameter int CYCLES_PER_US = CYC_PER_US
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic imgWrEn,
	input wire logic [5:0] imgWrAddr,
	input wire logic [7:0] imgWrData,
	input wire logic imgCommit,
	input wire logic paramWrEn,
	input wire logic [7:0] paramWrData,
	output logic [7:0] inputImageLength,
	output logic [7:0] outputImageLength,
	output toes_status_t inputStatusImage,
	output logic [3:0] outputChannels,
	output logic [31:0] usTicker
);
	localparam int SLOT_COUNT = LONG_VARIANT ? SLOTS_LONG : SLOTS_SHORT;
	localparam logic [7:0] OUT_LEN = LONG_VARIANT ? OUT_LEN_LONG : OUT_LEN_SHORT;
	localparam int IMG_BYTES = SLOTS_LONG * 4;
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam int PW = $clog2(CYCLES_PER_US);

	typedef enum logic {TOES_IDLE, TOES_SCAN} toes_scan_t;

	logic [7:0] image [IMG_BYTES];
	toes_entry_t fifoMem [FIFO_DEPTH];
	toes_scan_t scanState;
	logic [3:0] scanIdx;
	logic acceptedAny;
	logic [1:0] queueCode;
	logic [5:0] lastAccepted;
	logic [5:0] expectedSeq;
	logic [5:0] nextSeq;
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [CW-1:0] count;
	logic [CW-1:0] endCount;
	logic [PW-1:0] prescale;
	logic [5:0] slotBase;
	toes_entry_t slotEntry;
	toes_entry_t head;
	logic [5:0] age;
	logic isNew;
	logic isOld;
	logic lastSlot;
	logic fifoFull;
	logic push;
	logic pop;

	// parameters are constants; the write port is accepted and dropped
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			inputImageLength <= IN_LEN;
			outputImageLength <= OUT_LEN;
		end
		else
		begin
			inputImageLength <= IN_LEN;
			outputImageLength <= OUT_LEN;
		end
	end
	property p_in_len;
		@(posedge clk) disable iff (rst) inputImageLength == IN_LEN;
	endproperty
	a_in_len: assert property (p_in_len) else $error("input length changed");
	property p_out_len;
		@(posedge clk) disable iff (rst) outputImageLength == OUT_LEN;
	endproperty
	a_out_len: assert property (p_out_len) else $error("output length wrong");
	property p_param_hold;
		@(posedge clk) disable iff (rst)
			paramWrEn |=> $stable(inputImageLength) && $stable(outputImageLength);
	endproperty
	a_param_hold: assert property (p_param_hold) else $error("parameter moved");

	// output image bytes as last written; no reset, software fills it before commit
	always_ff @(posedge clk)
	begin
		if (imgWrEn && imgWrAddr < 6'(IMG_BYTES))
			image[imgWrAddr] <= imgWrData;
	end

	// decode the slot being scanned
	always_comb
	begin
		slotBase = {scanIdx, 2'h0};
		slotEntry.state = image[slotBase + OFS_STATE][7:4];
		slotEntry.state = {slotEntry.state[0], slotEntry.state[1],
			slotEntry.state[2], slotEntry.state[3]};
		slotEntry.seq = image[slotBase + OFS_SEQ][5:0];
		slotEntry.endFlag = image[slotBase + OFS_SEQ][SEQ_END_BIT];
		slotEntry.timeUs = {image[slotBase + OFS_TIME_HI], image[slotBase + OFS_TIME_LO]};
		age = expectedSeq - slotEntry.seq;
		isNew = slotEntry.seq == expectedSeq;
		// entries a few numbers behind are repeats of an old image, not errors
		isOld = age != 6'h00 && age <= 6'(SLOT_COUNT);
		lastSlot = scanIdx == 4'(SLOT_COUNT - 1);
	end

	assign head = fifoMem[rdPtr];
	assign fifoFull = count == CW'(FIFO_DEPTH);
	assign push = scanState == TOES_SCAN && isNew && !fifoFull;
	assign pop = count != '0 && head.timeUs == usTicker[15:0];

	// scan the image one slot per clock after each commit seen in TOES_IDLE
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			scanState <= TOES_IDLE;
			scanIdx <= 4'h0;
			acceptedAny <= 1'b0;
			queueCode <= CODE_NONE;
			lastAccepted <= 6'h00;
			expectedSeq <= SEQ_START;
		end
		else
		begin
			unique case (scanState)
				TOES_IDLE:
				begin
					if (imgCommit)
					begin
						scanState <= TOES_SCAN;
						scanIdx <= 4'h0;
						acceptedAny <= 1'b0;
					end
				end
				TOES_SCAN:
				begin
					if (isNew && fifoFull)
					begin
						queueCode <= CODE_FULL;
						scanState <= TOES_IDLE;
					end
					else if (isNew)
					begin
						lastAccepted <= slotEntry.seq;
						expectedSeq <= slotEntry.seq + 6'h01;
						acceptedAny <= 1'b1;
						if (slotEntry.endFlag || lastSlot)
						begin
							queueCode <= CODE_OK;
							scanState <= TOES_IDLE;
						end
						scanIdx <= scanIdx + 4'h1;
					end
					else if (isOld)
					begin
						if (slotEntry.endFlag || lastSlot)
						begin
							queueCode <= acceptedAny ? CODE_OK : CODE_NONE;
							scanState <= TOES_IDLE;
						end
						scanIdx <= scanIdx + 4'h1;
					end
					else
					begin
						queueCode <= CODE_MISMATCH;
						scanState <= TOES_IDLE;
					end
				end
			endcase
		end
	end
	property p_slot_bound;
		@(posedge clk) disable iff (rst) scanState == TOES_SCAN |-> scanIdx < 4'(SLOT_COUNT);
	endproperty
	a_slot_bound: assert property (p_slot_bound) else $error("scan past last slot");
	property p_seq_step;
		@(posedge clk) disable iff (rst)
			push |=> lastAccepted == $past(expectedSeq) && expectedSeq == $past(expectedSeq) + 6'h01;
	endproperty
	a_seq_step: assert property (p_seq_step) else $error("sequence not advanced");
	property p_end_stops;
		@(posedge clk) disable iff (rst) push && slotEntry.endFlag |=> scanState == TOES_IDLE;
	endproperty
	a_end_stops: assert property (p_end_stops) else $error("scan went past end mark");
	property p_mismatch;
		@(posedge clk) disable iff (rst) scanState == TOES_SCAN && !isNew && !isOld
			|=> ##1 inputStatusImage.queueState[1:0] == CODE_MISMATCH;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch not reported");

	// queue storage
	always_ff @(posedge clk)
	begin
		if (push)
			fifoMem[wrPtr] <= slotEntry;
	end

	// queue pointers, fill level and end-marker tally
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			endCount <= '0;
		end
		else
		begin
			if (push)
				wrPtr <= (wrPtr == AW'(FIFO_DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			if (pop)
				rdPtr <= (rdPtr == AW'(FIFO_DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			count <= count + CW'(push) - CW'(pop);
			endCount <= endCount + CW'(push && slotEntry.endFlag) - CW'(pop && head.endFlag);
		end
	end
	property p_push_count;
		@(posedge clk) disable iff (rst) push && !pop |=> count == $past(count) + 1'b1;
	endproperty
	a_push_count: assert property (p_push_count) else $error("entry not queued");

	// free-running microsecond ticker, wraps after all ones
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			prescale <= '0;
			usTicker <= 32'h00000000;
		end
		else if (prescale == PW'(CYCLES_PER_US - 1))
		begin
			prescale <= '0;
			usTicker <= usTicker + 32'h00000001;
		end
		else
			prescale <= prescale + 1'b1;
	end
	property p_ticker;
		@(posedge clk) disable iff (rst)
			prescale == PW'(CYCLES_PER_US - 1) |=> usTicker == $past(usTicker) + 32'h00000001;
	endproperty
	a_ticker: assert property (p_ticker) else $error("ticker did not step");

	// output channels; entries sharing one time are applied on successive clocks
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			outputChannels <= 4'h0;
		else if (pop)
			outputChannels <= head.state;
	end
	property p_apply;
		@(posedge clk) disable iff (rst) pop |=> outputChannels == $past(head.state);
	endproperty
	a_apply: assert property (p_apply) else $error("head state not applied");

	// status image, one clock behind the queue; the next-executed field two clocks behind
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			nextSeq <= 6'h00;
			inputStatusImage <= '0;
		end
		else
		begin
			if (count != '0)
				nextSeq <= head.seq;
			inputStatusImage.lastAccepted <= {LAST_TAG, lastAccepted};
			inputStatusImage.nextExecuted <= {NEXT_TAG, nextSeq};
			inputStatusImage.queueState <= {endCount != '0, 5'h00, queueCode};
			inputStatusImage.entryCount <= 8'(count);
		end
	end

	c_push: cover property (@(posedge clk) disable iff (rst) push);
	c_pop: cover property (@(posedge clk) disable iff (rst) pop);
	c_full: cover property (@(posedge clk) disable iff (rst) queueCode == CODE_FULL);
	c_end: cover property (@(posedge clk) disable iff (rst) push && slotEntry.endFlag);
endmodule

// ### verif/toes_bus_master.sv
// backplane bus master model that fills the output image and commits it
`timescale 1ns/10ps
module toes_bus_master
	import toes_pkg::*;
(
	input wire logic clk,
	output logic imgWrEn,
	output logic [5:0] imgWrAddr,
	output logic [7:0] imgWrData,
	output logic imgCommit,
	output logic paramWrEn,
	output logic [7:0] paramWrData
);
	// idle bus at time zero
	initial
	begin
		imgWrEn = 1'b0;
		imgWrAddr = 6'h00;
		imgWrData = 8'h00;
		imgCommit = 1'b0;
		paramWrEn = 1'b0;
		paramWrData = 8'h00;
	end
	// one entry is four bytes, state, sequence, time low, time high
	task automatic put_entry(input logic [5:0] slot, input logic [7:0] st,
		input logic [7:0] sq, input logic [15:0] t);
		logic [7:0] b [4];
		b = '{st, sq, t[7:0], t[15:8]};
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			#1;
			imgWrEn = 1'b1;
			imgWrAddr = 6'(slot * 4 + i);
			imgWrData = b[i];
		end
		@(posedge clk);
		#1;
		imgWrEn = 1'b0;
		imgWrData = ~imgWrData; // released data must not look valid
	endtask
	// single-cycle commit pulse starts the scan
	task automatic commit();
		@(posedge clk);
		#1;
		imgCommit = 1'b1;
		@(posedge clk);
		#1;
		imgCommit = 1'b0;
	endtask
	// record set only sent while the controller is stopped
	task automatic param_write(input logic [7:0] d);
		@(posedge clk);
		#1;
		paramWrEn = 1'b1;
		paramWrData = d;
		@(posedge clk);
		#1;
		paramWrEn = 1'b0;
		paramWrData = ~d;
	endtask
endmodule

// ### verif/test_timed_output_entry_scheduler.sv
// self-checking bench of the timed output entry scheduler
`timescale 1ns/10ps
module test_timed_output_entry_scheduler
	import toes_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic imgWrEn, imgCommit, paramWrEn;
	logic [5:0] imgWrAddr;
	logic [7:0] imgWrData, paramWrData, inLen, outLen;
	toes_status_t stat;
	logic [3:0] outCh;
	logic [31:0] ticker;
	logic [31:0] seed = 32'h7ff37660;
	logic [7:0] st [5];
	logic [15:0] t0;
	int failures = 0;
	int nCompared = 0;

	// small depth so the full code is reachable with five slots
	toes_scheduler #(.LONG_VARIANT(1'b0), .FIFO_DEPTH(4), .CYCLES_PER_US(2)) u_toes_scheduler (
		.clk(clk), .rst(rst), .imgWrEn(imgWrEn), .imgWrAddr(imgWrAddr),
		.imgWrData(imgWrData), .imgCommit(imgCommit), .paramWrEn(paramWrEn),
		.paramWrData(paramWrData), .inputImageLength(inLen), .outputImageLength(outLen),
		.inputStatusImage(stat), .outputChannels(outCh), .usTicker(ticker));
	toes_bus_master u_toes_bus_master (.clk(clk), .imgWrEn(imgWrEn), .imgWrAddr(imgWrAddr),
		.imgWrData(imgWrData), .imgCommit(imgCommit), .paramWrEn(paramWrEn),
		.paramWrData(paramWrData));

	always #5 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction
	// channel 0 follows state bit 7, channel 3 bit 4
	function automatic logic [3:0] exp_out(input logic [7:0] s);
		return {s[4], s[5], s[6], s[7]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d, failures %0d", nCompared, failures);
		if (failures == 0 && nCompared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// bounded wait for the queue level; a hang counts as a mismatch
	task automatic wait_count(input logic [7:0] n);
		int k;
		k = 0;
		while (stat.entryCount !== n && k < 2000)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		check(32'(k < 2000), 32'h1);
	endtask
	task automatic commit_wait();
		u_toes_bus_master.commit();
		repeat (SLOTS_SHORT + 4) @(posedge clk);
		#1;
	endtask

	initial
	begin
		#100000;
		failures++;
		stop_test();
	end

	initial
	begin
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		@(posedge clk);
		#1;
		check({inLen, outLen}, {IN_LEN, OUT_LEN_SHORT});
		check(stat, 32'h40c00200);
		check(ticker, 32'h00000000);
		// any twenty clocks hold exactly ten microsecond steps at two clocks per step
		t0 = ticker[15:0];
		repeat (20) @(posedge clk);
		#1;
		check(32'(ticker[15:0] - t0), 32'h0000000a);
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			u_toes_bus_master.param_write(seed[7:0]);
		end
		check({inLen, outLen}, {IN_LEN, OUT_LEN_SHORT});
		$display("test reset and lengths done");
		// five new entries into a four-deep queue: four stored, then full
		t0 = ticker[15:0];
		for (int i = 0; i < 5; i++)
		begin
			seed = xs(seed);
			st[i] = {seed[7:4], 4'h0};
			u_toes_bus_master.put_entry(6'(i), st[i], 8'(i + 1), t0 + 16'(100 + 20 * i));
		end
		commit_wait();
		check(stat, 32'h44c10304);
		for (int k = 0; k < 4; k++)
		begin
			wait_count(8'(3 - k));
			check(outCh, exp_out(st[k]));
		end
		$display("test fill and apply done");
		// slots 0..3 are old repeats, slot 4 is the next new entry
		u_toes_bus_master.put_entry(6'h04, st[4], 8'h05, ticker[15:0] + 16'h0032);
		commit_wait();
		check({stat.lastAccepted, stat.queueState, stat.entryCount}, 24'h450001);
		wait_count(8'h00);
		check(outCh, exp_out(st[4]));
		$display("test repeat skip done");
		// end-marked entry sets bit 7 of the queue state while queued
		u_toes_bus_master.put_entry(6'h00, 8'h90, 8'h46, ticker[15:0] + 16'h0032);
		commit_wait();
		check({stat.lastAccepted, stat.queueState}, 16'h4680);
		wait_count(8'h00);
		check({outCh, stat.queueState}, {exp_out(8'h90), 8'h00});
		// same image again holds nothing new
		commit_wait();
		check(stat.queueState, {6'h00, CODE_NONE});
		// sequence far from expected is refused
		seed = xs(seed);
		u_toes_bus_master.put_entry(6'h00, 8'hf0, {4'h2, seed[3:0]}, 16'h0000);
		commit_wait();
		check({stat.queueState, stat.entryCount}, {6'h00, CODE_MISMATCH, 8'h00});
		$display("test end mark and codes done");
		stop_test();
	end
endmodule
